// [core/rbs_slave_port.sv]
// rbs_slave_port: slave end of the byte-wide register bus with wait states.
// assumes the master logic runs on clk_sys_i, so its inputs need no synchroniser.
`timescale 1ns/1ps
// Summary of operation
// (RULE1) everything runs on the rising clock edge; up to 133 MHz supported.
// (RULE2) sync active-high reset clears interface and aborts cycle, not registers.
// (RULE3) master waits at least 1us after reset release before a cycle.
// (RULE4) reset may stay high any number of cycles.
// (RULE5) master raises cycle-valid for a cycle and strobe to select slave.
// (RULE6) slave answers an asserted strobe with acknowledge.
// (RULE7) write/read level: low reads, high writes, held through cycle.
// (RULE8) 8-bit address selects one register.
// (RULE9) separate 8-bit write and read byte paths, one byte per cycle.
// (RULE10) several masters go through user arbiter; only winner reaches slave.
// (RULE11) a write spans at least three clock edges.
// (RULE12) a read spans at least three clock edges.
// (RULE13) write starts with address, data, write high, valid and strobe together.
// (RULE14) read starts with address, write low, valid and strobe together.
// (RULE15) slave may add wait states; master holds request until acknowledge.
// (RULE16) master terminates on the edge after seeing acknowledge.
// (RULE17) at write end slave stores the byte; master drops its controls.
// (RULE18) read data is valid in the cycle acknowledge is high.
// (RULE19) at read end master takes data and drops strobe and valid.
// (RULE20) acknowledge drops when strobe goes, never spans into next cycle.
// (RULE21) acknowledge only with valid and strobe both high, once per cycle.
module rbs_slave_port #(
	parameter logic [7:0]  WAIT_STATES = rbs_pkg::WAIT_STATES,
	parameter int unsigned DEPTH       = 256
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       srst_i,
	input  wire logic                       cycle_valid_in_i,
	input  wire logic                       target_strobe_in_i,
	input  wire logic                       write_not_read_in_i,
	input  wire logic [rbs_pkg::ADDR_W-1:0] register_address_in_i,
	input  wire logic [rbs_pkg::DATA_W-1:0] write_byte_in_i,
	output logic      [rbs_pkg::DATA_W-1:0] read_byte_out_o,
	output logic                            transfer_ack_out_o
);
	// storage beyond the reach of an 8-bit address could never be selected
	if (DEPTH < 1 || DEPTH > (1 << rbs_pkg::ADDR_W)) begin : g_depth_check
		$error("rbs_slave_port: DEPTH out of range");
	end

	// live request decode, shared by the state logic and the store strobe
	function automatic logic req_selected(input rbs_pkg::rbs_req_t r);
		return r.cycle_valid && r.target_strobe;
	endfunction

	rbs_pkg::rbs_req_t   req;
	rbs_pkg::rbs_rsp_t   rsp_q, rsp_d;
	rbs_pkg::rbs_state_t state_q, state_d;
	logic [7:0]                 wait_q, wait_d;
	logic                       wr_en;
	logic [rbs_pkg::DATA_W-1:0] rd_data;
	logic                       sel;
	logic [8:0]                 span_q, span_d;

	assign req = '{cycle_valid:      cycle_valid_in_i,
	               target_strobe:    target_strobe_in_i,
	               write_not_read:   write_not_read_in_i,
	               register_address: register_address_in_i,
	               write_byte:       write_byte_in_i};
	assign sel = req_selected(req); // [RULE21]

	rbs_regfile #(
		.DEPTH     (DEPTH)
	) u_regs (
		.clk_sys_i (clk_sys_i),
		.wr_en_i   (wr_en),
		.wr_addr_i (req.register_address),
		.wr_data_i (req.write_byte),
		.rd_addr_i (req.register_address),
		.rd_data_o (rd_data)
	);

	// store happens on the edge that ends the ack cycle, as the master leaves;
	// a lingering strobe or a reset on that edge must not store again
	assign wr_en = rsp_q.transfer_ack && req_selected(req) && !srst_i
	               && req.write_not_read; // [RULE17] [RULE9] [RULE7]

	always_comb begin
		state_d = state_q;
		wait_d  = wait_q;
		rsp_d   = rsp_q;
		rsp_d.transfer_ack = 1'b0;
		case (state_q)
			rbs_pkg::RBS_IDLE: begin
				// decode edge: request seen, answer comes one edge later at the earliest
				if (sel) begin // [RULE6] [RULE8]
					wait_d  = WAIT_STATES;
					state_d = rbs_pkg::RBS_WAIT;
				end
			end
			rbs_pkg::RBS_WAIT: begin
				if (!sel) begin
					state_d = rbs_pkg::RBS_IDLE;
				end else if (wait_q != 8'h00) begin // [RULE15]
					wait_d = wait_q - 8'h01;
				end else begin
					rsp_d.transfer_ack = 1'b1; // [RULE6] [RULE11] [RULE12]
					rsp_d.read_byte    = req.write_not_read ? rsp_q.read_byte : rd_data; // [RULE18]
					state_d = rbs_pkg::RBS_ACK;
				end
			end
			rbs_pkg::RBS_ACK: begin
				// one ack per cycle: wait for the strobe to drop before rearming
				state_d = sel ? rbs_pkg::RBS_ACK : rbs_pkg::RBS_IDLE; // [RULE20] [RULE21]
			end
			default: state_d = rbs_pkg::RBS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin // [RULE1]
		if (srst_i) begin // [RULE2] [RULE4]
			state_q <= rbs_pkg::RBS_IDLE;
			wait_q  <= 8'h00;
			rsp_q   <= '0;
		end else begin
			state_q <= state_d;
			wait_q  <= wait_d;
			rsp_q   <= rsp_d;
		end
	end

	// cycles since the request was taken; only chk_ack_span reads it
	always_comb begin
		span_d = span_q;
		if (state_q == rbs_pkg::RBS_IDLE) begin
			span_d = 9'h000;
		end else if (span_q != 9'h1ff) begin
			span_d = span_q + 9'h001;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			span_q <= 9'h000;
		end else begin
			span_q <= span_d;
		end
	end

	assign transfer_ack_out_o = rsp_q.transfer_ack;
	assign read_byte_out_o    = rsp_q.read_byte;

	sequence s_req_start;
		!sel ##1 sel;
	endsequence

	chk_ack_needs_sel: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		transfer_ack_out_o |-> $past(sel)) // [RULE21]
		else $error("ack without valid and strobe");
	chk_ack_single: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		transfer_ack_out_o |=> !transfer_ack_out_o) // [RULE20]
		else $error("ack held longer than one cycle");
	chk_ack_earliest: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_req_start |-> !transfer_ack_out_o ##1 !transfer_ack_out_o) // [RULE11] [RULE12]
		else $error("ack came too early");
	chk_ack_timely: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(s_req_start ##1 sel [*1]) |-> ##[0:300] (transfer_ack_out_o || !sel)) // [RULE6] [RULE15]
		else $error("ack never came");
	chk_read_data: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(transfer_ack_out_o && !req.write_not_read) |-> read_byte_out_o == $past(rd_data)) // [RULE18]
		else $error("read data not valid with ack");
	chk_write_store: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_en |-> $past(transfer_ack_out_o == 1'b0) && state_q == rbs_pkg::RBS_ACK) // [RULE17]
		else $error("write stored outside ack");
	chk_reset_clear: assert property (@(posedge clk_sys_i)
		srst_i |=> !transfer_ack_out_o && state_q == rbs_pkg::RBS_IDLE) // [RULE2] [RULE4]
		else $error("reset did not abort cycle");
	chk_state_onehot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$onehot(state_q)) // [RULE1]
		else $error("state not one-hot");

	// steps of one transfer as the port sees them
	sequence s_taken;
		state_q == rbs_pkg::RBS_IDLE && sel;
	endsequence

	sequence s_cut;
		state_q == rbs_pkg::RBS_WAIT && !sel;
	endsequence

	sequence s_write_end;
		transfer_ack_out_o && sel && req.write_not_read;
	endsequence

	// answer timing
	chk_taken_waits: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_taken |=> state_q == rbs_pkg::RBS_WAIT && !transfer_ack_out_o) // [RULE6] [RULE11]
		else $error("request not taken into the wait state");
	chk_ack_span: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		transfer_ack_out_o |-> span_q == 9'(WAIT_STATES) + 9'h001) // [RULE12] [RULE15]
		else $error("ack not after the set number of wait states");
	chk_ack_min_span: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		transfer_ack_out_o |-> $past(sel) && $past(sel, 2)) // [RULE11] [RULE12]
		else $error("ack sooner than three edges after the request");
	chk_wait_step: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(state_q == rbs_pkg::RBS_WAIT && sel && wait_q != 8'h00)
		|=> !transfer_ack_out_o && wait_q == $past(wait_q) - 8'h01) // [RULE15]
		else $error("wait state skipped");

	// refusals and single answers
	chk_cut_no_ack: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_cut |=> !transfer_ack_out_o && state_q == rbs_pkg::RBS_IDLE) // [RULE21]
		else $error("dropped strobe still answered");
	chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		state_q == rbs_pkg::RBS_IDLE |=> !transfer_ack_out_o) // [RULE6] [RULE21]
		else $error("ack straight from idle");
	chk_linger_no_ack: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(state_q == rbs_pkg::RBS_ACK && sel) |=> !transfer_ack_out_o) // [RULE21]
		else $error("second ack for one held strobe");
	chk_ack_released: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(state_q == rbs_pkg::RBS_ACK && !sel) |=> state_q == rbs_pkg::RBS_IDLE) // [RULE20]
		else $error("port not rearmed after strobe dropped");

	// data paths and reset
	chk_write_lands: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_write_end |-> wr_en) // [RULE17] [RULE9]
		else $error("acknowledged write not stored");
	chk_write_once: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_en |-> (sel && req.write_not_read) ##1 !wr_en) // [RULE7] [RULE21]
		else $error("write strobe repeated or unqualified");
	chk_read_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$changed(read_byte_out_o) |-> transfer_ack_out_o || $past(srst_i)) // [RULE18]
		else $error("read byte moved outside an acknowledged read");
	chk_reset_read: assert property (@(posedge clk_sys_i)
		srst_i |=> read_byte_out_o == 8'h00) // [RULE2] [RULE4]
		else $error("reset left read byte set");
endmodule

// [inc/rbs_pkg.sv]
// rbs_pkg: shared constants and carrier types for the register bus slave port.
// assumes a single 40 MHz system clock and a byte-wide register map.
package rbs_pkg;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	// master must idle this long after reset release
	localparam int unsigned RST_GAP_NS    = 1000;
	localparam int unsigned RST_GAP_CYC   = (RST_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0]  WAIT_STATES   = 8'h00;
	localparam logic [7:0]  REG_RESET_VAL = 8'h00;

	typedef struct packed {
		logic                   cycle_valid;
		logic                   target_strobe;
		logic                   write_not_read;
		logic [ADDR_W-1:0]      register_address;
		logic [DATA_W-1:0]      write_byte;
	} rbs_req_t;

	typedef struct packed {
		logic                   transfer_ack;
		logic [DATA_W-1:0]      read_byte;
	} rbs_rsp_t;

	typedef enum logic [2:0] {
		RBS_IDLE = 3'b001,
		RBS_WAIT = 3'b010,
		RBS_ACK  = 3'b100
	} rbs_state_t;
endpackage

// [core/rbs_regfile.sv]
// rbs_regfile: byte register map reached by the bus slave port.
// assumes writes come as single-cycle strobes; contents have no reset on purpose.
`timescale 1ns/1ps
module rbs_regfile #(
	parameter int unsigned DEPTH = 256
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       wr_en_i,
	input  wire logic [rbs_pkg::ADDR_W-1:0] wr_addr_i,
	input  wire logic [rbs_pkg::DATA_W-1:0] wr_data_i,
	input  wire logic [rbs_pkg::ADDR_W-1:0] rd_addr_i,
	output logic      [rbs_pkg::DATA_W-1:0] rd_data_o
);
	if (DEPTH < 1 || DEPTH > (1 << rbs_pkg::ADDR_W)) begin : g_depth_check
		$error("rbs_regfile: DEPTH out of range");
	end

	logic [rbs_pkg::DATA_W-1:0] mem_q [DEPTH];

	// bus reset deliberately does not reach the storage [RULE2]
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_reg
			always_ff @(posedge clk_sys_i) begin
				if (wr_en_i && 32'(wr_addr_i) == 32'(g))
					mem_q[g] <= wr_data_i; // [RULE17]
			end
		end
	endgenerate

	// unmapped addresses read as the reset pattern
	always_comb begin
		if (32'(rd_addr_i) < DEPTH)
			rd_data_o = mem_q[rd_addr_i];
		else
			rd_data_o = rbs_pkg::REG_RESET_VAL;
	end
endmodule

// [bench/rbs_master_model.sv]
// rbs_master_model: behavioural bus master facing the slave port.
// assumes go_i is a one-cycle pulse given only while the bus is idle.
`timescale 1ns/1ps
module rbs_master_model (
	input  wire logic                       clk_sys_i,
	input  wire logic                       go_i,
	input  wire logic                       abort_i,
	input  wire logic                       we_i,
	input  wire logic [rbs_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [rbs_pkg::DATA_W-1:0] dat_i,
	input  wire logic                       ack_i,
	input  wire logic [rbs_pkg::DATA_W-1:0] rdat_i,
	output rbs_pkg::rbs_req_t               req_o,
	output logic                            done_o,
	output logic [rbs_pkg::DATA_W-1:0]      rdat_o
);
	initial begin
		req_o = '0;
		done_o = 1'b0;
		rdat_o = '0;
	end
	always @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		if (req_o.target_strobe && (ack_i || abort_i)) begin
			// released lines show the inverse so a stale value never passes for a live one
			req_o <= {3'b000, ~req_o.register_address, ~req_o.write_byte};
			if (ack_i) begin
				rdat_o <= rdat_i;
				done_o <= 1'b1;
			end
		end else if (go_i && !req_o.target_strobe) begin
			// one master only, so no arbiter stands in front of the slave
			req_o <= {2'b11, we_i, adr_i, dat_i};
		end
	end // request held unchanged until acknowledge or abort_i
endmodule

// [bench/tb.sv]
// tb: random write/read traffic, aborts and resets against the slave port.
// assumes the master model holds each request until acknowledge or abort.
`timescale 1ns/1ps
module tb;
	localparam int WS = 2;
	logic              clk_sys_i = 1'b0;
	logic              srst_i = 1'b1;
	logic              go = 1'b0;
	logic              abort = 1'b0;
	logic              we = 1'b0;
	logic [7:0]        adr = '0;
	logic [7:0]        dat = '0;
	logic [7:0]        rdat;
	logic [7:0]        rd_byte;
	logic              ack;
	logic              done;
	rbs_pkg::rbs_req_t req;
	logic [7:0]        shadow [256];
	int                bad_count = 0;
	int                samples_checked = 0;
	int                acks = 0;

	rbs_slave_port #(.WAIT_STATES(8'(WS)), .DEPTH(256)) DUT (.clk_sys_i(clk_sys_i),
		.srst_i(srst_i), .cycle_valid_in_i(req.cycle_valid),
		.target_strobe_in_i(req.target_strobe), .write_not_read_in_i(req.write_not_read),
		.register_address_in_i(req.register_address), .write_byte_in_i(req.write_byte),
		.read_byte_out_o(rd_byte), .transfer_ack_out_o(ack));
	rbs_master_model master (.clk_sys_i(clk_sys_i), .go_i(go), .abort_i(abort), .we_i(we),
		.adr_i(adr), .dat_i(dat), .ack_i(ack), .rdat_i(rd_byte), .req_o(req), .done_o(done),
		.rdat_o(rdat));

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// counted mid-cycle so the count never races the clock edge
	always @(negedge clk_sys_i) if (ack === 1'b1) acks++;

	// edges from the go pulse until done is seen: take, decode, wait states, ack, done
	function automatic int exp_lat();
		return 4 + WS;
	endfunction

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int lat;
		lat = 0;
		acks = 0;
		@(posedge clk_sys_i);
		go <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_sys_i);
		go <= 1'b0;
		while (done !== 1'b1 && lat < 50) begin
			@(posedge clk_sys_i);
			lat++;
		end
		@(posedge clk_sys_i);
		check("latency_ok", 8'h01, 8'(lat == exp_lat()));
		check("ack_count", 8'h01, 8'(acks));
	endtask

	task automatic cut_write(input logic [7:0] a, input logic rst);
		acks = 0;
		@(posedge clk_sys_i);
		go <= 1'b1;
		we <= 1'b1;
		adr <= a;
		dat <= ~shadow[a];
		@(posedge clk_sys_i);
		go <= 1'b0;
		abort <= 1'b1;
		srst_i <= rst;
		@(posedge clk_sys_i);
		abort <= 1'b0;
		repeat ($urandom_range(8, 1)) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		repeat (rbs_pkg::RST_GAP_CYC) @(posedge clk_sys_i);
		check("cut_ack_count", 8'h00, 8'(acks));
		xfer(1'b0, a, 8'h00);
		check("kept_byte", shadow[a], rdat);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		logic [7:0] a;
		logic [7:0] d;
		void'($urandom(32'h2a6a05b5));
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		repeat (rbs_pkg::RST_GAP_CYC) @(posedge clk_sys_i);
		for (int i = 0; i < 24; i++) begin
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			d = 8'($urandom);
			xfer(1'b1, a, d);
			shadow[a] = d;
			xfer(1'b0, a, 8'h00);
			check("read_byte", shadow[a], rdat);
		end
		cut_write(a, 1'b0);
		cut_write(a, 1'b1);
		final_report();
	end

	initial begin
		#500000;
		bad_count++;
		final_report();
	end
endmodule
